// File: verilog/rfm_params.svh
// Constants for the refresh-mask and oscillator-count mode registers.
// Assumes inclusion by bare name from files under verilog/ and tb/.
`ifndef RFM_PARAMS_SVH
`define RFM_PARAMS_SVH

`define RFM_MA_W            6
`define RFM_OP_W            8
`define RFM_MA_BANK_MASK    6'h10
`define RFM_MA_SEG_MASK     6'h11
`define RFM_MA_OSC_LOW      6'h12
`define RFM_MA_OSC_HIGH     6'h13
`define RFM_MASK_RESET      8'h00
`define RFM_OSC_RESET       16'h0000
`define RFM_OSC_MAX         16'hFFFF
`define RFM_RD_IDLE         8'h00
`define RFM_CHANNELS        2
`define RFM_NOSEG_HI_BITS   2'h0
`define RFM_SEG_KEEP_W      6
`define RFM_SEG_W           3
`define RFM_SEG_LSB_1G      10
`define RFM_SEG_LSB_2G      11
`define RFM_SEG_LSB_4G      12
`define RFM_SEG_LSB_8G      13
`define RFM_DENS_1G         2'h0
`define RFM_DENS_2G         2'h1
`define RFM_DENS_4G         2'h2

`endif

// File: verilog/rfm_pkg.sv
// Types shared by both ends of the mode-register link.
// Assumes rfm_params.svh is on the include path.
`include "rfm_params.svh"

package rfm_pkg;

    typedef logic [`RFM_MA_W-1:0] rfm_addr_type;
    typedef logic [`RFM_OP_W-1:0] rfm_byte_type;

    typedef enum logic [1:0] {
        RFM_CMD_WRITE,
        RFM_CMD_READ,
        RFM_CMD_OSC_START,
        RFM_CMD_OSC_STOP
    } rfm_cmd_type;

endpackage : rfm_pkg

// File: verilog/rfm_link_if.sv
// Mode-register command link between controller and device.
// Assumes one shared clock; the testbench connects both modports.
`timescale 1ns/100ps
`default_nettype none

interface rfm_link_if;
    logic                 cmd_valid;
    rfm_pkg::rfm_cmd_type cmd;
    rfm_pkg::rfm_addr_type mode_reg_address;
    rfm_pkg::rfm_byte_type operand_bits;
    logic                 chan_sel;
    logic                 rd_valid;
    rfm_pkg::rfm_byte_type rd_data;

    modport ctrl (
        output cmd_valid, cmd, mode_reg_address, operand_bits, chan_sel,
        input  rd_valid, rd_data
    );
    modport dev (
        input  cmd_valid, cmd, mode_reg_address, operand_bits, chan_sel,
        output rd_valid, rd_data
    );
endinterface : rfm_link_if

`default_nettype wire

// File: verilog/rfm_chan_regs.sv
// One channel's refresh masks and oscillator counter.
// Assumes decoded strobes from the device end on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "rfm_params.svh"

module rfm_chan_regs #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Strobes
    input  wire logic             wr_bank_i,
    input  wire logic             wr_seg_i,
    input  wire logic             osc_start_i,
    input  wire logic             osc_stop_i,
    input  wire logic             osc_tick_i,
    input  wire logic [7:0]       wdata_i,
    // State
    output logic      [7:0]       bank_mask_o,
    output logic      [7:0]       seg_mask_o,
    output logic      [CNT_W-1:0] osc_count_o,
    output logic                  osc_running_o
);
    // The count is read back as exactly two mode-register bytes
    if (CNT_W != 2 * `RFM_OP_W) begin : g_cnt_chk
        $error("rfm_chan_regs: count must be two bytes");
    end

    logic [7:0]       bank_q;
    logic [7:0]       seg_q;
    logic [CNT_W-1:0] cnt_q;
    logic             run_q;
    wire              cnt_sat = (cnt_q == `RFM_OSC_MAX);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bank_q <= `RFM_MASK_RESET;
            seg_q  <= `RFM_MASK_RESET;
        end else begin
            if (wr_bank_i) begin
                bank_q <= wdata_i;
            end
            if (wr_seg_i) begin
                seg_q <= wdata_i;
            end
        end
    end

    // Counter saturates rather than wrapping so a long run stays monotone
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= `RFM_OSC_RESET;
            run_q <= 1'b0;
        end else if (osc_start_i) begin
            cnt_q <= `RFM_OSC_RESET;
            run_q <= 1'b1;
        end else if (osc_stop_i) begin
            run_q <= 1'b0;
        end else if (run_q && osc_tick_i && !cnt_sat) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign bank_mask_o   = bank_q;
    assign seg_mask_o    = seg_q;
    assign osc_count_o   = cnt_q;
    assign osc_running_o = run_q;
endmodule : rfm_chan_regs

`default_nettype wire

// File: verilog/rfm_device.sv
// Device end: decodes mode-register commands for two channels.
// Assumes the controller holds each command for one clock only.
`timescale 1ns/100ps
`default_nettype none
`include "rfm_params.svh"

module rfm_device #(
    parameter int ROW_W = 17
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               sys_rst_i,
    // Link
    rfm_link_if.dev                 link,
    // Oscillator ticks, one per channel, from the DQS oscillator
    input  wire logic [1:0]         osc_tick_i,
    // Refresh engine query
    input  wire logic               ref_chan_i,
    input  wire logic [2:0]         ref_bank_i,
    input  wire logic [ROW_W-1:0]   ref_row_i,
    input  wire logic [1:0]         density_sel_i,
    output logic                    ref_bank_skip_o,
    output logic                    ref_seg_skip_o,
    // Observed state
    output logic [1:0]              osc_running_o
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The row port must reach the widest density's segment bits
    if (ROW_W < 17) begin : g_row_chk
        $error("rfm_device: row address too narrow");
    end
    // Channel select and tick vector are one and two bits wide
    if (`RFM_CHANNELS != 2) begin : g_chan_chk
        $error("rfm_device: exactly two channels are served");
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire is_wr   = link.cmd_valid && (link.cmd == rfm_pkg::RFM_CMD_WRITE);
    wire is_rd   = link.cmd_valid && (link.cmd == rfm_pkg::RFM_CMD_READ);
    wire is_st   = link.cmd_valid && (link.cmd == rfm_pkg::RFM_CMD_OSC_START);
    wire is_sp   = link.cmd_valid && (link.cmd == rfm_pkg::RFM_CMD_OSC_STOP);
    wire hit_bk  = (link.mode_reg_address == `RFM_MA_BANK_MASK);
    wire hit_sg  = (link.mode_reg_address == `RFM_MA_SEG_MASK);
    wire hit_lo  = (link.mode_reg_address == `RFM_MA_OSC_LOW);
    wire hit_hi  = (link.mode_reg_address == `RFM_MA_OSC_HIGH);
    // Writes aimed at the read-only counts match no strobe and are lost
    wire wr_bank = is_wr && hit_bk;
    wire wr_seg  = is_wr && hit_sg;
    wire rd_osc  = is_rd && (hit_lo || hit_hi);

    logic [7:0]  bank_mask [`RFM_CHANNELS];
    logic [7:0]  seg_mask  [`RFM_CHANNELS];
    logic [15:0] osc_cnt   [`RFM_CHANNELS];

    // ------------------------------------------------------------
    // Per-channel register sets
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `RFM_CHANNELS; ch++) begin : g_ch
            wire sel      = (link.chan_sel == 1'(ch));
            wire ch_wrb   = wr_bank && sel;
            wire ch_wrs   = wr_seg && sel;
            wire ch_start = is_st && sel;
            wire ch_stop  = is_sp && sel;
            rfm_chan_regs #(.CNT_W(16)) u_regs (
                .clk_i         (clk_i),
                .sys_rst_i     (sys_rst_i),
                .wr_bank_i     (ch_wrb),
                .wr_seg_i      (ch_wrs),
                .osc_start_i   (ch_start),
                .osc_stop_i    (ch_stop),
                .osc_tick_i    (osc_tick_i[ch]),
                .wdata_i       (link.operand_bits),
                .bank_mask_o   (bank_mask[ch]),
                .seg_mask_o    (seg_mask[ch]),
                .osc_count_o   (osc_cnt[ch]),
                .osc_running_o (osc_running_o[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode-register read; masks are write-only and read as zero
    // ------------------------------------------------------------
    // Both bytes come from the channel named in the read itself
    wire [15:0] rd_cnt     = osc_cnt[link.chan_sel];
    wire [7:0]  rd_lo_byte = rd_cnt[`RFM_OP_W-1:0];
    wire [7:0]  rd_hi_byte = rd_cnt[2*`RFM_OP_W-1:`RFM_OP_W];
    wire [7:0]  rd_mux     = hit_lo ? rd_lo_byte :
                             hit_hi ? rd_hi_byte :
                             `RFM_RD_IDLE;
    // Idle between answers keeps the data lines at a known zero
    wire [7:0]  rd_data_d  = rd_osc ? rd_mux : `RFM_RD_IDLE;
    logic [7:0] rd_data_q;
    logic       rd_valid_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_data_q  <= `RFM_RD_IDLE;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= is_rd;
            rd_data_q  <= rd_data_d;
        end
    end

    assign link.rd_valid = rd_valid_q;
    assign link.rd_data  = rd_data_q;

    // ------------------------------------------------------------
    // Refresh skip query
    // ------------------------------------------------------------
    // Density 0:1Gb 1:2Gb 2:3/4Gb 3:6/8Gb; 12/16Gb not selectable,
    // so the top row bit only widens the port for a later density
    wire [2:0] seg_1g  = ref_row_i[`RFM_SEG_LSB_1G +: `RFM_SEG_W];
    wire [2:0] seg_2g  = ref_row_i[`RFM_SEG_LSB_2G +: `RFM_SEG_W];
    wire [2:0] seg_4g  = ref_row_i[`RFM_SEG_LSB_4G +: `RFM_SEG_W];
    wire [2:0] seg_8g  = ref_row_i[`RFM_SEG_LSB_8G +: `RFM_SEG_W];
    wire       is_1g   = (density_sel_i == `RFM_DENS_1G);
    wire       is_2g   = (density_sel_i == `RFM_DENS_2G);
    wire       is_4g   = (density_sel_i == `RFM_DENS_4G);
    wire [2:0] seg_idx = is_1g ? seg_1g :
                         is_2g ? seg_2g :
                         is_4g ? seg_4g :
                                 seg_8g;

    // Both channels are looked up and the query's channel picks one
    wire [1:0] bank_hit;
    wire [1:0] seg_hit;
    for (genvar qc = 0; qc < `RFM_CHANNELS; qc++) begin : g_query
        assign bank_hit[qc] = bank_mask[qc][ref_bank_i];
        assign seg_hit[qc]  = seg_mask[qc][seg_idx];
    end

    assign ref_bank_skip_o = bank_hit[ref_chan_i];
    assign ref_seg_skip_o  = seg_hit[ref_chan_i];
endmodule : rfm_device

`default_nettype wire

// File: verilog/rfm_controller.sv
// Controller end: issues mode-register commands and joins count bytes.
// Assumes one request at a time from the user side.
`timescale 1ns/100ps
`default_nettype none
`include "rfm_params.svh"

module rfm_controller (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // User requests
    input  wire logic         req_valid_i,
    input  wire logic [1:0]   req_kind_i,
    input  wire logic         req_chan_i,
    input  wire logic [7:0]   req_bank_mask_i,
    input  wire logic [7:0]   req_seg_mask_i,
    input  wire logic         odd_density_i,
    output logic              req_ready_o,
    output logic              cnt_valid_o,
    output logic [15:0]       cnt_o,
    // Link
    rfm_link_if.ctrl          link
);
    typedef enum logic [2:0] {
        RFM_IDLE, RFM_WR_SEG, RFM_RD_LO, RFM_WAIT_LO, RFM_WAIT_HI
    } rfm_cst_type;

    rfm_cst_type st_q;
    logic [7:0]  lo_q;
    logic [7:0]  seg_q;
    logic        chan_q;
    logic [15:0] cnt_q;
    logic        cv_q;

    // Kinds: 0 write masks, 1 osc start, 2 osc stop, 3 read count
    wire take = req_valid_i && (st_q == RFM_IDLE);
    wire [7:0] seg_safe = odd_density_i ?
        {`RFM_NOSEG_HI_BITS, req_seg_mask_i[`RFM_SEG_KEEP_W-1:0]} :
        req_seg_mask_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q   <= RFM_IDLE;
            lo_q   <= `RFM_RD_IDLE;
            seg_q  <= `RFM_MASK_RESET;
            chan_q <= 1'b0;
            cnt_q  <= `RFM_OSC_RESET;
            cv_q   <= 1'b0;
        end else begin
            cv_q <= 1'b0;
            unique case (st_q)
                RFM_IDLE: begin
                    if (take) begin
                        chan_q <= req_chan_i;
                        seg_q  <= seg_safe;
                        if (req_kind_i == 2'h0) begin
                            st_q <= RFM_WR_SEG;
                        end else if (req_kind_i == 2'h3) begin
                            st_q <= RFM_RD_LO;
                        end
                    end
                end
                RFM_WR_SEG:  st_q <= RFM_IDLE;
                RFM_RD_LO:   st_q <= RFM_WAIT_LO;
                RFM_WAIT_LO: begin
                    if (link.rd_valid) begin
                        lo_q <= link.rd_data;
                        st_q <= RFM_WAIT_HI;
                    end
                end
                RFM_WAIT_HI: begin
                    if (link.rd_valid) begin
                        cnt_q <= {link.rd_data, lo_q};
                        cv_q  <= 1'b1;
                        st_q  <= RFM_IDLE;
                    end
                end
            endcase
        end
    end

    // Commands are combinational handshake outputs, one clock each
    wire in_idle = (st_q == RFM_IDLE);
    assign req_ready_o = in_idle;
    // A read request spends its taking cycle silent, then reads low, high
    assign link.cmd_valid = (take && req_kind_i != 2'h3)
                         || (st_q == RFM_WR_SEG)
                         || (st_q == RFM_RD_LO) || (st_q == RFM_WAIT_LO);
    assign link.cmd = (take && req_kind_i == 2'h1) ? rfm_pkg::RFM_CMD_OSC_START :
                      (take && req_kind_i == 2'h2) ? rfm_pkg::RFM_CMD_OSC_STOP :
                      (in_idle && req_kind_i == 2'h0) ? rfm_pkg::RFM_CMD_WRITE :
                      (st_q == RFM_WR_SEG) ? rfm_pkg::RFM_CMD_WRITE :
                      rfm_pkg::RFM_CMD_READ;
    assign link.mode_reg_address =
        in_idle ? `RFM_MA_BANK_MASK :
        (st_q == RFM_WR_SEG) ? `RFM_MA_SEG_MASK :
        (st_q == RFM_RD_LO) ? `RFM_MA_OSC_LOW : `RFM_MA_OSC_HIGH;
    assign link.operand_bits = in_idle ? req_bank_mask_i : seg_q;
    assign link.chan_sel = in_idle ? req_chan_i : chan_q;
    assign cnt_valid_o = cv_q;
    assign cnt_o = cnt_q;
endmodule : rfm_controller

`default_nettype wire

// File: tb/rfm_link_chk.sv
// Assertions on the mode-register link between both ends.
// Assumes the bench wires it beside the link interface.
`timescale 1ns/100ps
`default_nettype none
`include "rfm_params.svh"

module rfm_link_chk (
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  sys_rst_i,
    // Link signals
    input wire logic                  cmd_valid,
    input wire logic [1:0]            cmd,
    input wire rfm_pkg::rfm_addr_type mode_reg_address,
    input wire logic                  chan_sel,
    input wire logic                  rd_valid,
    input wire rfm_pkg::rfm_byte_type rd_data
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    wire rd_c  = cmd_valid && cmd == rfm_pkg::RFM_CMD_READ;
    wire wr_c  = cmd_valid && cmd == rfm_pkg::RFM_CMD_WRITE;
    wire rd_lo = rd_c && mode_reg_address == `RFM_MA_OSC_LOW;
    wire wr_lo = wr_c && mode_reg_address == `RFM_MA_BANK_MASK;

    rd_answer_a:
        assert property (rd_c |=> rd_valid)
        else $error("read not answered");
    rd_cause_a:
        assert property (rd_valid |-> $past(rd_c))
        else $error("read data without a read");
    rd_idle_a:
        assert property (!rd_valid |-> rd_data == `RFM_RD_IDLE)
        else $error("read data not idle");
    wr_target_a:
        assert property (wr_c |-> mode_reg_address
            inside {`RFM_MA_BANK_MASK, `RFM_MA_SEG_MASK})
        else $error("write to a read-only place");
    pair_read_a:
        assert property (rd_lo |=> rd_c && $stable(chan_sel)
            && mode_reg_address == `RFM_MA_OSC_HIGH)
        else $error("high byte read missing");
    pair_write_a:
        assert property (wr_lo |=> wr_c && $stable(chan_sel)
            && mode_reg_address == `RFM_MA_SEG_MASK)
        else $error("segment write missing");
    reset_quiet_a:
        assert property ($fell(sys_rst_i) |-> !cmd_valid && !rd_valid)
        else $error("link busy after reset");
    no_spurious_a:
        assert property (cmd_valid && !rd_c |=> !rd_valid)
        else $error("answer to a non-read");
endmodule : rfm_link_chk

`default_nettype wire

// File: tb/refresh_mask_and_osc_count_regs_tb_top.sv
// Bench joining controller and device ends over the link.
// Assumes the design files and package are compiled first.
`timescale 1ns/100ps
`default_nettype none

module refresh_mask_and_osc_count_regs_tb_top;
    // ----
    // Stimulus and hookup
    // ----
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        req_valid = 1'b0;
    logic [1:0]  req_kind = 2'h0;
    logic        req_chan = 1'b0;
    logic [7:0]  bank_m = 8'h00;
    logic [7:0]  seg_m = 8'h00;
    logic        odd_d = 1'b0;
    logic [1:0]  tick = 2'h0;
    logic        ref_chan = 1'b0;
    logic [2:0]  ref_bank = 3'h0;
    logic [16:0] ref_row = 17'h00000;
    logic [1:0]  dens = 2'h0;
    wire         ready, cnt_valid, bank_skip, seg_skip;
    wire  [15:0] cnt;
    wire  [1:0]  running;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;

    rfm_link_if u_rfm_link_if ();
    rfm_device u_rfm_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link(u_rfm_link_if.dev), .osc_tick_i(tick), .ref_chan_i(ref_chan),
        .ref_bank_i(ref_bank), .ref_row_i(ref_row), .density_sel_i(dens),
        .ref_bank_skip_o(bank_skip), .ref_seg_skip_o(seg_skip),
        .osc_running_o(running));
    rfm_controller u_rfm_controller (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid), .req_kind_i(req_kind), .req_chan_i(req_chan),
        .req_bank_mask_i(bank_m), .req_seg_mask_i(seg_m),
        .odd_density_i(odd_d), .req_ready_o(ready), .cnt_valid_o(cnt_valid),
        .cnt_o(cnt), .link(u_rfm_link_if.ctrl));
    rfm_link_chk u_rfm_link_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cmd_valid(u_rfm_link_if.cmd_valid), .cmd(u_rfm_link_if.cmd),
        .mode_reg_address(u_rfm_link_if.mode_reg_address),
        .chan_sel(u_rfm_link_if.chan_sel), .rd_valid(u_rfm_link_if.rd_valid),
        .rd_data(u_rfm_link_if.rd_data));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            $display("unexpected at %0t: run timed out", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask : check

    // Request is held until the edge that sees ready high
    task automatic req(input logic [1:0] kind, input logic ch,
                       input logic [7:0] bm, input logic [7:0] sm);
        @(posedge clk_i);
        req_valid <= 1'b1;
        req_kind <= kind;
        req_chan <= ch;
        bank_m <= bm;
        seg_m <= sm;
        @(negedge clk_i);
        while (ready !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        req_valid <= 1'b0;
    endtask : req

    task automatic idle();
        @(negedge clk_i);
        while (ready !== 1'b1) @(negedge clk_i);
    endtask : idle

    task automatic rd_cnt(input logic ch, input logic [15:0] exp);
        req(2'h3, ch, 8'h00, 8'h00);
        @(negedge clk_i);
        while (cnt_valid !== 1'b1) @(negedge clk_i);
        check(cnt, exp, "count");
    endtask : rd_cnt

    task automatic ref_chk(input logic ch, input logic [2:0] b,
                           input logic [16:0] row, input logic [1:0] d,
                           input logic eb, input logic es);
        @(posedge clk_i);
        ref_chan <= ch;
        ref_bank <= b;
        ref_row <= row;
        dens <= d;
        @(negedge clk_i);
        check(16'(bank_skip), 16'(eb), "bank skip");
        check(16'(seg_skip), 16'(es), "segment skip");
    endtask : ref_chk

    task automatic t_reset();
        for (int i = 0; i < 16; i++) begin
            ref_chk(i[3], i[2:0], 17'(i[2:0]) << 13, 2'h3, 1'b0, 1'b0);
        end
        rd_cnt(1'b0, 16'h0000);
        $display("reset test done");
    endtask : t_reset

    task automatic t_masks();
        logic [7:0] bm[2];
        logic [7:0] sm[2];
        bm = '{8'hA5, 8'h3C};
        sm = '{8'h81, 8'h5A};
        req(2'h0, 1'b0, bm[0], sm[0]);
        req(2'h0, 1'b1, bm[1], sm[1]);
        idle();
        for (int i = 0; i < 64; i++) begin
            ref_chk(i[0], i[3:1], 17'(i[3:1]) << (10 + i[5:4]), i[5:4],
                    bm[i[0]][i[3:1]], sm[i[0]][i[3:1]]);
        end
        $display("mask test done");
    endtask : t_masks

    // Segments 6 and 7 must stay refreshed at odd densities
    task automatic t_odd();
        @(posedge clk_i);
        odd_d <= 1'b1;
        req(2'h0, 1'b0, 8'h00, 8'hFF);
        idle();
        for (int s = 5; s < 8; s++) begin
            ref_chk(1'b0, 3'h0, 17'(s) << 12, 2'h2, 1'b0, s == 5);
        end
        @(posedge clk_i);
        odd_d <= 1'b0;
        $display("odd density test done");
    endtask : t_odd

    task automatic t_osc();
        req(2'h1, 1'b0, 8'h00, 8'h00);
        idle();
        check(16'(running), 16'h0001, "running");
        @(posedge clk_i);
        tick <= 2'h3;
        repeat (300) @(posedge clk_i);
        tick <= 2'h0;
        req(2'h2, 1'b0, 8'h00, 8'h00);
        idle();
        check(16'(running), 16'h0000, "stopped");
        @(posedge clk_i);
        tick <= 2'h3;
        rd_cnt(1'b0, 16'h012C);
        rd_cnt(1'b0, 16'h012C);
        rd_cnt(1'b1, 16'h0000);
        @(posedge clk_i);
        tick <= 2'h0;
        req(2'h1, 1'b0, 8'h00, 8'h00);
        rd_cnt(1'b0, 16'h0000);
        $display("oscillator test done");
    endtask : t_osc

    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_masks();
        t_odd();
        t_osc();
        finish_test();
    end
endmodule : refresh_mask_and_osc_count_regs_tb_top

`default_nettype wire
